// ==== usb_xfer_regs.svh ====
// constants for the transfer status queue and its register window
// assumes the includer uses them against 8-bit register data
`ifndef USB_XFER_REGS_SVH
`define USB_XFER_REGS_SVH

// register selects on the register access port
`define SEL_STATUS_WINDOW 2'h0
`define SEL_INT_FLAGS     2'h1
`define SEL_INT_ENABLES   2'h2

// status entry layout
`define ST_ENDP_HI  6
`define ST_ENDP_LO  3
`define ST_DIR_BIT  2
`define ST_PINGPONG_BUFFER_INDICATOR_BIT 1

// interrupt flag and enable bit positions
`define FLAG_IDLE_BIT 4
`define FLAG_TRN_BIT  3
`define FLAG_MASK     8'h18
`define ENABLES_MASK  8'h7f
`define REG_RESET     8'h00

// queue shape
`define QUEUE_DEPTH 3'd4
`define QUEUE_EMPTY 3'd0
`define QUEUE_ONE   3'd1

// timing
`define CLK_PERIOD_NS    4
`define IDLE_TIME_US     3000
`define TCY_NS           4
`define REASSERT_MAX_TCY 5
`define IDLE_CNT_W       20
`define IDLE_CNT_ZERO    20'h00000
`define IDLE_CNT_ONE     20'h00001

`endif

// ==== usb_xfer_pkg.sv ====
// types shared by the transfer status queue and its owner
// assumes usb_xfer_regs.svh is on the include path
`include "usb_xfer_regs.svh"
package usb_xfer_pkg;
   typedef logic [7:0] status_entry_t;
   typedef logic [2:0] queue_count_t;
   typedef logic [1:0] queue_ptr_t;

   // packs one completed transfer into the status byte layout
   function automatic status_entry_t make_entry(input logic [3:0] endp,
                                                input logic       dir,
                                                input logic       pingpong_buffer_indicator);
      status_entry_t e;
      e = 8'h00;
      e[`ST_ENDP_HI:`ST_ENDP_LO] = endp;
      e[`ST_DIR_BIT] = dir;
      e[`ST_PINGPONG_BUFFER_INDICATOR_BIT] = pingpong_buffer_indicator;
      return e;
   endfunction
endpackage

// ==== status_queue_if.sv ====
// carrier between the status logic and its entry queue
// assumes both ends share clk_sys
interface status_queue_if;
   usb_xfer_pkg::status_entry_t push_data;
   logic                        push;
   logic                        pop;
   logic                        flush;
   usb_xfer_pkg::status_entry_t head;
   usb_xfer_pkg::queue_count_t  count;
   logic                        full;

   modport owner (output push, push_data, pop, flush, input head, count, full);
   modport queue (input push, push_data, pop, flush, output head, count, full);
endinterface

// ==== status_queue.sv ====
// four-entry status queue in flip-flops, oldest entry at the head
// assumes the owner never pops an empty queue on purpose; such pops are ignored
`include "usb_xfer_regs.svh"
module status_queue (
   input wire logic clk_sys,
   input wire logic srst,
   status_queue_if.queue q
);
   usb_xfer_pkg::status_entry_t mem [4];
   usb_xfer_pkg::queue_ptr_t    rd_ptr;
   usb_xfer_pkg::queue_ptr_t    wr_ptr;
   usb_xfer_pkg::queue_count_t  count;
   usb_xfer_pkg::queue_ptr_t    next_rd_ptr;
   usb_xfer_pkg::queue_ptr_t    next_wr_ptr;
   usb_xfer_pkg::queue_count_t  next_count;
   logic                        do_push;
   logic                        do_pop;

   always_comb begin
      // push refused when full unless a pop frees a slot in the same cycle, so stored entries are never overwritten
      do_pop = q.pop && (count != `QUEUE_EMPTY);
      do_push = q.push && ((count != `QUEUE_DEPTH) || do_pop);
      next_rd_ptr = rd_ptr;
      next_wr_ptr = wr_ptr;
      next_count = count;
      if (q.flush) begin
         next_rd_ptr = '0;
         next_wr_ptr = '0;
         next_count = `QUEUE_EMPTY;
      end else begin
         if (do_pop) next_rd_ptr = rd_ptr + 2'd1;
         if (do_push) next_wr_ptr = wr_ptr + 2'd1;
         if (do_push && !do_pop) next_count = count + `QUEUE_ONE;
         else if (do_pop && !do_push) next_count = count - `QUEUE_ONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= `QUEUE_EMPTY;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
      end
   end

   // entry storage needs no reset; the head is only meaningful while count is nonzero
   always_ff @(posedge clk_sys) begin
      if (do_push && !q.flush) mem[wr_ptr] <= q.push_data;
   end

   assign q.head = mem[rd_ptr];
   assign q.count = count;
   assign q.full = (count == `QUEUE_DEPTH);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   queue_depth_a: assert property (count <= `QUEUE_DEPTH)
      else $error("status queue holds more than four entries");
   push_store_a: assert property (q.push && !q.pop && !q.flush && !q.full
                                  |=> count == $past(count) + `QUEUE_ONE)
      else $error("accepted push did not add an entry");
   no_overwrite_a: assert property (q.full && q.push && !q.pop && !q.flush
                                    |=> q.full && $stable(rd_ptr) && $stable(wr_ptr))
      else $error("push into full queue disturbed stored entries");
   pop_advance_a: assert property (q.pop && !q.push && !q.flush && count != `QUEUE_EMPTY
                                   |=> count == $past(count) - `QUEUE_ONE
                                       && rd_ptr == $past(rd_ptr) + 2'd1)
      else $error("pop did not advance the head");
   fifo_order_a: assert property (q.push && !q.flush && count == `QUEUE_EMPTY
                                  ##1 !q.flush |-> q.head == $past(q.push_data))
      else $error("first pushed entry is not at the head");
   flush_empty_a: assert property (q.flush |=> count == `QUEUE_EMPTY)
      else $error("flush left entries in the queue");
endmodule

// ==== usb_transfer_status_fifo.sv ====
// transfer status reporting: status queue, flag and enable registers, bus idle,
// nak on full, pull-up and transceiver supply gating
// assumes all inputs synchronous to clk_sys; register access is a byte port
`include "usb_xfer_regs.svh"
module usb_transfer_status_fifo #(
   parameter int IDLE_CYCLES = (`IDLE_TIME_US * 1000) / `CLK_PERIOD_NS
) (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       xfer_done,
   input  wire logic [3:0] xfer_endp,
   input  wire logic       xfer_dir,
   input  wire logic       xfer_pingpong_buffer_indicator,
   input  wire logic       ep_request,
   input  wire logic       bus_activity,
   input  wire logic       usb_module_enable,
   input  wire logic       regulator_enable_cfg,
   input  wire logic [1:0] sfr_sel,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            nak_handshake,
   output logic            usb_event,
   output logic            pullup_enable,
   output logic            transceiver_supply_pin
);
   localparam int REASSERT_CYC = (`REASSERT_MAX_TCY * `TCY_NS) / `CLK_PERIOD_NS;
   localparam logic [`IDLE_CNT_W-1:0] IDLE_LIMIT = `IDLE_CNT_W'(IDLE_CYCLES);

   status_queue_if q ();

   logic                  transfer_done_flag;
   logic                  bus_idle_flag;
   logic [7:0]            usb_interrupt_enables;
   logic [`IDLE_CNT_W-1:0] idle_cnt;
   logic                  next_transfer_done_flag;
   logic                  next_bus_idle_flag;
   logic [7:0]            next_usb_interrupt_enables;
   logic [`IDLE_CNT_W-1:0] next_idle_cnt;
   logic [7:0]            next_sfr_rdata;
   logic                  next_nak_handshake;
   logic                  next_usb_event;
   logic                  next_pullup_enable;
   logic                  next_transceiver_supply_pin;
   logic [7:0]            usb_interrupt_flags;
   logic [7:0]            transfer_status_window;
   logic                  flags_wr;
   logic                  clr_trn;
   logic                  clr_idle;
   logic                  idle_hit;

   status_queue u_queue (
      .clk_sys (clk_sys),
      .srst    (srst),
      .q       (q)
   );

   always_comb begin
      // module disable doubles as the queue reset and also blocks new entries
      q.push = xfer_done && usb_module_enable;
      q.push_data = usb_xfer_pkg::make_entry(xfer_endp, xfer_dir, xfer_pingpong_buffer_indicator);
      q.flush = !usb_module_enable;
   end

   always_comb begin
      flags_wr = sfr_wr && (sfr_sel == `SEL_INT_FLAGS);
      // flags clear by writing zero; writing one leaves them alone
      clr_trn = flags_wr && !sfr_wdata[`FLAG_TRN_BIT];
      clr_idle = flags_wr && !sfr_wdata[`FLAG_IDLE_BIT];
      q.pop = clr_trn && transfer_done_flag;
      usb_interrupt_flags = 8'h00;
      usb_interrupt_flags[`FLAG_TRN_BIT] = transfer_done_flag;
      usb_interrupt_flags[`FLAG_IDLE_BIT] = bus_idle_flag;
      // window content only trusted while the flag is set; zero otherwise
      transfer_status_window = transfer_done_flag ? q.head : 8'h00;
   end

   always_comb begin
      next_transfer_done_flag = transfer_done_flag;
      if (!usb_module_enable) next_transfer_done_flag = 1'b0;
      else if (clr_trn) next_transfer_done_flag = 1'b0;
      // a one-cycle gap after the clear marks the pop, well inside the allowed delay
      else if (q.count != `QUEUE_EMPTY) next_transfer_done_flag = 1'b1;
   end

   always_comb begin
      next_idle_cnt = idle_cnt;
      idle_hit = 1'b0;
      if (!usb_module_enable || bus_activity) next_idle_cnt = `IDLE_CNT_ZERO;
      // count parks at the limit so a long suspend cannot wrap and set it twice
      else if (idle_cnt != IDLE_LIMIT) begin
         next_idle_cnt = idle_cnt + `IDLE_CNT_ONE;
         idle_hit = (next_idle_cnt == IDLE_LIMIT);
      end
      next_bus_idle_flag = bus_idle_flag;
      if (!usb_module_enable) next_bus_idle_flag = 1'b0;
      else if (idle_hit) next_bus_idle_flag = 1'b1; // set wins over a same-cycle clear
      else if (clr_idle) next_bus_idle_flag = 1'b0;
   end

   always_comb begin
      next_usb_interrupt_enables = usb_interrupt_enables;
      if (sfr_wr && sfr_sel == `SEL_INT_ENABLES)
         next_usb_interrupt_enables = sfr_wdata & `ENABLES_MASK;
      next_sfr_rdata = sfr_rdata;
      if (sfr_rd) begin
         case (sfr_sel)
            `SEL_STATUS_WINDOW: next_sfr_rdata = transfer_status_window;
            `SEL_INT_FLAGS:     next_sfr_rdata = usb_interrupt_flags;
            `SEL_INT_ENABLES:   next_sfr_rdata = usb_interrupt_enables;
            default:            next_sfr_rdata = 8'h00;
         endcase
      end
      next_nak_handshake = ep_request && q.full;
      next_usb_event = |(usb_interrupt_flags & usb_interrupt_enables & `FLAG_MASK);
      // suspend does not touch the pull-up; only the module enable does
      next_pullup_enable = usb_module_enable;
      next_transceiver_supply_pin = regulator_enable_cfg && usb_module_enable;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         transfer_done_flag <= 1'b0;
         bus_idle_flag <= 1'b0;
         usb_interrupt_enables <= `REG_RESET;
         idle_cnt <= `IDLE_CNT_ZERO;
         sfr_rdata <= `REG_RESET;
         nak_handshake <= 1'b0;
         usb_event <= 1'b0;
         pullup_enable <= 1'b0;
         transceiver_supply_pin <= 1'b0;
      end else begin
         transfer_done_flag <= next_transfer_done_flag;
         bus_idle_flag <= next_bus_idle_flag;
         usb_interrupt_enables <= next_usb_interrupt_enables;
         idle_cnt <= next_idle_cnt;
         sfr_rdata <= next_sfr_rdata;
         nak_handshake <= next_nak_handshake;
         usb_event <= next_usb_event;
         pullup_enable <= next_pullup_enable;
         transceiver_supply_pin <= next_transceiver_supply_pin;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   entry_layout_a: assert property (sfr_rd && sfr_sel == `SEL_STATUS_WINDOW
                                    |=> sfr_rdata[7] == 1'b0 && sfr_rdata[0] == 1'b0)
      else $error("status byte has bits outside its fields");
   window_valid_a: assert property (sfr_rd && sfr_sel == `SEL_STATUS_WINDOW
                                    && transfer_done_flag |=> sfr_rdata == $past(q.head))
      else $error("status window does not show the head entry");
   window_zero_a: assert property (sfr_rd && sfr_sel == `SEL_STATUS_WINDOW
                                   && !transfer_done_flag |=> sfr_rdata == `REG_RESET)
      else $error("status window not blanked while the flag is clear");
   flag_has_entry_a: assert property (transfer_done_flag |-> q.count != `QUEUE_EMPTY)
      else $error("transfer flag set with the queue empty");
   flag_clear_a: assert property (clr_trn && usb_module_enable |=> !transfer_done_flag)
      else $error("software clear did not drop the transfer flag");
   // reassert bound counts from the edge after the clear, in clk_sys cycles
   reassert_a: assert property (transfer_done_flag && clr_trn && usb_module_enable
                                && q.count > `QUEUE_ONE
                                ##1 (!clr_trn && usb_module_enable)
                                |-> ##[1:REASSERT_CYC] transfer_done_flag)
      else $error("flag not set again with entries pending");
   stay_clear_a: assert property (transfer_done_flag && clr_trn && !xfer_done
                                  && q.count == `QUEUE_ONE ##1 !xfer_done
                                  |=> !transfer_done_flag)
      else $error("flag came back with nothing queued");
   nak_on_full_a: assert property (ep_request && q.full |=> nak_handshake)
      else $error("request while full was not answered with nak");
   no_nak_free_a: assert property (!q.full |=> !nak_handshake)
      else $error("nak issued while queue had room");
   nak_answer_a: assert property (nak_handshake |-> $past(ep_request) && $past(q.full))
      else $error("nak issued without a request while full");
   idle_set_a: assert property (usb_module_enable && !bus_activity
                                && idle_cnt == IDLE_LIMIT - `IDLE_CNT_ONE
                                |=> bus_idle_flag)
      else $error("bus idle flag missing after idle time");
   idle_early_a: assert property ($rose(bus_idle_flag) |-> idle_cnt == IDLE_LIMIT)
      else $error("bus idle flag set before idle time");
   activity_reset_a: assert property (bus_activity |=> idle_cnt == `IDLE_CNT_ZERO)
      else $error("bus traffic did not restart the idle count");
   pullup_hold_a: assert property (bus_idle_flag && usb_module_enable
                                   |=> pullup_enable)
      else $error("pull-up dropped during suspend");
   supply_gate_a: assert property (transceiver_supply_pin
                                   |-> $past(regulator_enable_cfg) && $past(usb_module_enable))
      else $error("supply driven without both enables");
   supply_on_a: assert property (regulator_enable_cfg && usb_module_enable
                                 |=> transceiver_supply_pin)
      else $error("supply not driven with both enables set");
   reset_clear_a: assert property (!usb_module_enable |=> !transfer_done_flag
                                   && q.count == `QUEUE_EMPTY)
      else $error("queue reset left entries or flag");

   fill_queue_c: cover property (q.full ##1 ep_request);
   pop_refill_c: cover property (clr_trn && transfer_done_flag ##2 transfer_done_flag);
   idle_seen_c: cover property ($rose(bus_idle_flag));
   event_out_c: cover property ($rose(usb_event));
   reset_flush_c: cover property (!usb_module_enable && q.count != `QUEUE_EMPTY);
endmodule

// ==== usb_host_model.sv ====
// usb host stand-in: endpoint requests, bus traffic, bus power detect
// assumes the device samples its inputs on the rising edge of clk_sys
module usb_host_model (
   input  wire logic clk_sys,
   input  wire logic quiet,
   input  wire logic nak_handshake,
   output logic      ep_request,
   output logic      bus_activity,
   output logic      vbus_on
);
   timeunit 1ns;
   timeprecision 1ps;

   // traffic stops only when the bench asks for a suspend
   always_comb bus_activity = !quiet;

   initial begin
      ep_request = 1'b0;
      vbus_on = 1'b0;
      // bus power comes some cycles after attach; software waits for it
      repeat (6) @(negedge clk_sys);
      vbus_on = 1'b1;
   end

   // one request, answer sampled while the registered nak stands
   task automatic request(output logic got);
      @(negedge clk_sys);
      ep_request = 1'b1;
      @(negedge clk_sys);
      ep_request = 1'b0;
      got = nak_handshake;
   endtask
endmodule

// ==== usb_transfer_status_fifo_bench.sv ====
// self-checking bench for the transfer status queue block
// assumes usb_host_model.sv and the design files are compiled before it
`include "usb_xfer_regs.svh"
module usb_transfer_status_fifo_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // short idle limit keeps the run small
   localparam int IDLE = 20;
   logic       clk_sys = 1'b0;
   logic       srst = 1'b1;
   logic       xfer_done = 1'b0;
   logic [3:0] xfer_endp = 4'h0;
   logic       xfer_dir = 1'b0;
   logic       xfer_pingpong_buffer_indicator = 1'b0;
   logic       quiet = 1'b0;
   logic       usb_module_enable = 1'b0;
   logic       regulator_enable_cfg = 1'b0;
   logic [1:0] sfr_sel = 2'h0;
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic       ep_request, bus_activity, vbus_on, nak_handshake;
   logic       usb_event, pullup_enable, transceiver_supply_pin;
   logic [7:0] d;
   logic       got;
   int         n_mismatch = 0;
   int         checks = 0;
   usb_xfer_pkg::status_entry_t exp_q[$];

   always #2 clk_sys = ~clk_sys;

   usb_transfer_status_fifo #(.IDLE_CYCLES(IDLE)) u_dut (.clk_sys(clk_sys), .srst(srst),
      .xfer_done(xfer_done), .xfer_endp(xfer_endp), .xfer_dir(xfer_dir),
      .xfer_pingpong_buffer_indicator(xfer_pingpong_buffer_indicator), .ep_request(ep_request), .bus_activity(bus_activity),
      .usb_module_enable(usb_module_enable), .regulator_enable_cfg(regulator_enable_cfg),
      .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .nak_handshake(nak_handshake), .usb_event(usb_event),
      .pullup_enable(pullup_enable), .transceiver_supply_pin(transceiver_supply_pin));

   usb_host_model u_host (.clk_sys(clk_sys), .quiet(quiet), .nak_handshake(nak_handshake),
      .ep_request(ep_request), .bus_activity(bus_activity), .vbus_on(vbus_on));

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [1:0] s, input logic [7:0] v);
      @(negedge clk_sys);
      sfr_sel = s;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [1:0] s, output logic [7:0] v);
      @(negedge clk_sys);
      sfr_sel = s;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      v = sfr_rdata;
   endtask

   function automatic logic [7:0] entry(input logic [3:0] e, input logic dr, input logic pp);
      return {1'b0, e, dr, pp, 1'b0};
   endfunction

   // back-to-back completions; beyond four the queue must drop them
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         xfer_done = 1'b1;
         xfer_endp = (i == 0) ? 4'hf : 4'($urandom);
         xfer_dir = 1'($urandom);
         xfer_pingpong_buffer_indicator = 1'($urandom);
         if (exp_q.size() < 4) exp_q.push_back(entry(xfer_endp, xfer_dir, xfer_pingpong_buffer_indicator));
      end
      @(negedge clk_sys);
      xfer_done = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask

   // flag read lands five cycles after each clear edge
   task automatic drain();
      while (exp_q.size() > 0) begin
         rd(2'h1, d);
         chk(d, 8'h08);
         rd(2'h0, d);
         chk(d, exp_q.pop_front());
         wr(2'h1, 8'hf7);
         repeat (3) @(negedge clk_sys);
      end
      rd(2'h1, d);
      chk(d, 8'h00);
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(negedge clk_sys);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h43890e15));
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      for (int s = 0; s < 4; s++) begin
         rd(2'(s), d);
         chk(d, `REG_RESET);
      end
      for (int i = 0; i < 50 && !vbus_on; i++) @(negedge clk_sys);
      chk({7'h0, vbus_on}, 8'h01);
      usb_module_enable = 1'b1;
      regulator_enable_cfg = 1'b1;
      wr(2'h2, 8'hff);
      rd(2'h2, d);
      chk(d, `ENABLES_MASK);
      wr(2'h0, 8'hff);
      rd(2'h0, d);
      chk(d, 8'h00);
      $display("test registers done");
      push(2);
      chk({7'h0, usb_event}, 8'h01);
      drain();
      chk({7'h0, usb_event}, 8'h00);
      $display("test queue order done");
      push(5);
      u_host.request(got);
      chk({7'h0, got}, 8'h01);
      drain();
      u_host.request(got);
      chk({7'h0, got}, 8'h00);
      $display("test full queue done");
      push(3);
      @(negedge clk_sys);
      usb_module_enable = 1'b0;
      @(negedge clk_sys);
      usb_module_enable = 1'b1;
      exp_q.delete();
      rd(2'h1, d);
      chk(d, 8'h00);
      push(1);
      drain();
      $display("test queue reset done");
      quiet = 1'b1;
      repeat (IDLE - 5) @(negedge clk_sys);
      rd(2'h1, d);
      chk(d, 8'h00);
      repeat (10) @(negedge clk_sys);
      rd(2'h1, d);
      chk(d, 8'h10);
      chk({7'h0, pullup_enable}, 8'h01);
      quiet = 1'b0;
      wr(2'h1, 8'hef);
      rd(2'h1, d);
      chk(d, 8'h00);
      $display("test bus idle done");
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         regulator_enable_cfg = i[0];
         usb_module_enable = i[1];
         repeat (2) @(negedge clk_sys);
         chk({7'h0, transceiver_supply_pin}, {7'h0, i == 3});
         chk({7'h0, pullup_enable}, {7'h0, i[1]});
      end
      $display("test supply gating done");
      wrap_up();
   end
endmodule
